// [inc/keyport_params.svh]
// Offsets, field positions, reset values and timing for the keystroke port
// Behaviour
// - Packet is 19 inputs then 6 outputs
// - Long gap returns position to bit one
// - Bits 1-8 are character, LSB first
// - Bits 9-16 are the eight modifiers
// - Bit 17 selects send or status only
// - Bits 20-22 return num, caps, scroll
// - Bits 23-25 reserved, still clocked out
// - Shifted characters gain a shift modifier
// - Keep below 18 ms, restart above 20
// - Status-only packet sends no keystroke
`ifndef KEYPORT_PARAMS_SVH
`define KEYPORT_PARAMS_SVH

// ==========================================================
// Packet layout
`define IN_BITS      19
`define OUT_BITS     6
`define PKT_BITS     25
`define CHAR_LSB     0
`define MOD_LSB      8
`define CMD_POS      16
`define LSHIFT_POS   1

// ==========================================================
// Timing
`define CLK_MHZ      20
`define TICK_US      1000
`define TICK_CYCLES  (`TICK_US * `CLK_MHZ)
`define GAP_MS       19

// ==========================================================
// Register map
`define KEY_OFS      4'h0
`define LOCK_OFS     4'h4
`define STAT_OFS     4'h8
`define KEY_VALID_POS 16
`define LOCK_RST     3'h0

`endif

// [inc/keyport_pkg.sv]
// Types shared by the keystroke port
`default_nettype none
package keyport_pkg;
    typedef enum logic [2:0] {
        S_IDLE    = 3'b001,
        S_PRESENT = 3'b010,
        S_HOLD    = 3'b100
    } port_state_t;
endpackage : keyport_pkg
`default_nettype wire

// [verilog/gap_timer.sv]
// Inactivity timer measuring the gap between serial strobe edges
`timescale 1ns/10ps
`default_nettype none
module gap_timer #(
    parameter int TICK_CYCLES = 20000,
    parameter int GAP_TICKS   = 19
) (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic restart,
    output logic      expired
);
    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam int GW = $clog2(GAP_TICKS + 1);

    generate
        if (TICK_CYCLES < 1 || GAP_TICKS < 1) begin : g_bad
            $error("gap_timer: counts must be positive");
        end
    endgenerate

    logic [TW-1:0] div_r;
    logic [GW-1:0] ms_r;
    wire           tick = (div_r == TW'(TICK_CYCLES - 1));

    // ==========================================================
    // Divider and tick counter; restart realigns both so the gap is exact
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            div_r <= '0;
            ms_r  <= '0;
        end else if (restart) begin
            div_r <= '0;
            ms_r  <= '0;
        end else begin
            div_r <= tick ? '0 : div_r + TW'(1);
            if (tick && !expired)
                ms_r <= ms_r + GW'(1);
        end
    end

    assign expired = (ms_r == GW'(GAP_TICKS));
endmodule : gap_timer
`default_nettype wire

// [verilog/keyport.sv]
// Serial keystroke packet port with Wishbone register access
//
// Added by the designer: register access over Wishbone and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "keyport_params.svh"
module keyport #(
    parameter int TICK_CYCLES = `TICK_CYCLES,
    parameter int GAP_MS      = `GAP_MS
) (
    input  wire logic        CLOCK,
    input  wire logic        RST_B,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [3:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    input  wire logic        SER_STROBE_B,
    input  wire logic        SER_DATA_I,
    output logic             SER_DATA_O,
    output logic             SER_DATA_OE,
    output logic             SER_BUSY,
    output logic             KEY_SEND,
    output logic      [7:0]  KEY_CHAR,
    output logic      [7:0]  KEY_MOD
);
    generate
        if (GAP_MS <= 18 || GAP_MS >= 20) begin : g_bad
            $error("keyport: gap must lie between 18 and 20 ms");
        end
    endgenerate

    // ==========================================================
    // Shift-needed decode for printable characters
    function automatic logic needs_shift(input logic [7:0] c);
        needs_shift = (c >= 8'h41 && c <= 8'h5A) ||
                      (c >= 8'h21 && c <= 8'h26) ||
                      (c >= 8'h28 && c <= 8'h2B) ||
                      c == 8'h3A || c == 8'h3C || c == 8'h3E ||
                      c == 8'h3F || c == 8'h40 || c == 8'h5E ||
                      c == 8'h5F || (c >= 8'h7B && c <= 8'h7E);
    endfunction : needs_shift

    // ==========================================================
    // Pin synchronisers
    logic [1:0] meta_r;
    logic [1:0] sync_r;
    logic       strobe_d_r;
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            meta_r     <= 2'h3;
            sync_r     <= 2'h3;
            strobe_d_r <= 1'b1;
        end else begin
            meta_r     <= {SER_DATA_I, SER_STROBE_B};
            sync_r     <= meta_r;
            strobe_d_r <= sync_r[0];
        end
    end
    wire strobe_s  = sync_r[0];
    wire data_s    = sync_r[1];
    wire strobe_fl = strobe_d_r & ~strobe_s;
    wire strobe_rs = ~strobe_d_r & strobe_s;

    // ==========================================================
    // Gap timer, restarted on every strobe edge
    wire gap_out;
    gap_timer #(
        .TICK_CYCLES (TICK_CYCLES),
        .GAP_TICKS   (GAP_MS)
    ) u_gap (
        .clk     (CLOCK),
        .rst_b   (RST_B),
        .restart (strobe_fl | strobe_rs),
        .expired (gap_out)
    );
    // Expiry holds until the next edge; that edge opens a fresh packet
    wire gap_rst = gap_out & ~strobe_fl & ~strobe_rs;

    // ==========================================================
    // Packet engine
    keyport_pkg::port_state_t state_r;
    keyport_pkg::port_state_t state_nxt;
    logic [4:0]            pos_r;
    logic [`IN_BITS-1:0]   in_r;
    logic [2:0]            lock_r;
    logic                  valid_r;

    wire       in_phase  = (pos_r < 5'(`IN_BITS));
    wire       last_bit  = (pos_r == 5'(`PKT_BITS - 1));
    wire [4:0] out_idx   = pos_r - 5'(`IN_BITS);
    wire [7:0] out_vec   = {5'h00, lock_r};
    wire       out_bit   = out_vec[out_idx[2:0]];
    wire       pkt_done  = (state_r == keyport_pkg::S_HOLD) && strobe_rs &&
                           last_bit;
    wire [7:0] char_w    = in_r[`CHAR_LSB +: 8];
    wire       shift_w   = needs_shift(char_w);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            keyport_pkg::S_IDLE:
                if (strobe_fl)
                    state_nxt = in_phase ? keyport_pkg::S_HOLD
                                         : keyport_pkg::S_PRESENT;
            keyport_pkg::S_PRESENT:
                state_nxt = keyport_pkg::S_HOLD;
            keyport_pkg::S_HOLD:
                if (strobe_rs)
                    state_nxt = keyport_pkg::S_IDLE;
            default:
                state_nxt = keyport_pkg::S_IDLE;
        endcase
        if (gap_rst)
            state_nxt = keyport_pkg::S_IDLE;
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            state_r <= keyport_pkg::S_IDLE;
            pos_r   <= 5'h00;
            in_r    <= '0;
        end else begin
            state_r <= state_nxt;
            if (gap_rst)
                pos_r <= 5'h00;
            else if (state_r == keyport_pkg::S_HOLD && strobe_rs)
                pos_r <= last_bit ? 5'h00 : pos_r + 5'h01;
            if (state_r == keyport_pkg::S_IDLE && strobe_fl && in_phase)
                in_r[pos_r] <= data_s;
        end
    end

    // ==========================================================
    // Pin drivers
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            SER_BUSY    <= 1'b0;
            SER_DATA_O  <= 1'b0;
            SER_DATA_OE <= 1'b0;
        end else begin
            SER_BUSY    <= (state_nxt == keyport_pkg::S_HOLD);
            SER_DATA_O  <= out_bit;
            SER_DATA_OE <= !in_phase &&
                           state_nxt != keyport_pkg::S_IDLE;
        end
    end

    // ==========================================================
    // Keystroke hand-off after the full packet
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            KEY_SEND <= 1'b0;
            KEY_CHAR <= 8'h00;
            KEY_MOD  <= 8'h00;
        end else begin
            KEY_SEND <= pkt_done && !in_r[`CMD_POS];
            if (pkt_done && !in_r[`CMD_POS]) begin
                KEY_CHAR <= char_w;
                KEY_MOD  <= in_r[`MOD_LSB +: 8] |
                            {6'h00, shift_w, 1'b0};
            end
        end
    end

    // ==========================================================
    // Wishbone slave, one wait state
    wire       req    = WB_CYC_I & WB_STB_I;
    wire       wr_go  = req & WB_WE_I & WB_ACK_O;
    wire       hit_k  = (WB_ADR_I == `KEY_OFS);
    wire       hit_l  = (WB_ADR_I == `LOCK_OFS);
    wire       hit_s  = (WB_ADR_I == `STAT_OFS);
    wire       clr_v  = wr_go & hit_k & WB_SEL_I[2] &
                        WB_DAT_I[`KEY_VALID_POS];
    wire [31:0] rd_w  =
        hit_k ? {15'h0000, valid_r, KEY_MOD, KEY_CHAR} :
        hit_l ? {29'h00000000, lock_r} :
        hit_s ? {24'h000000, SER_DATA_OE, SER_BUSY, 1'b0, pos_r} :
                32'h00000000;

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h00000000;
            lock_r   <= `LOCK_RST;
            valid_r  <= 1'b0;
        end else begin
            WB_ACK_O <= req & ~WB_ACK_O;
            if (req & ~WB_ACK_O)
                WB_DAT_O <= rd_w;
            if (wr_go & hit_l & WB_SEL_I[0])
                lock_r <= WB_DAT_I[2:0];
            // New keystroke wins over a clear
            if (KEY_SEND)
                valid_r <= 1'b1;
            else if (clr_v)
                valid_r <= 1'b0;
        end
    end
endmodule : keyport
`default_nettype wire

// [sim/keyport_monitor.sv]
// Checker for the serial handshake of the keystroke port
`timescale 1ns/10ps
`default_nettype none
module keyport_monitor (
    input wire logic       CLOCK,
    input wire logic       RST_B,
    input wire logic       SER_STROBE_B,
    input wire logic       SER_DATA_OE,
    input wire logic       SER_BUSY,
    input wire logic       KEY_SEND,
    input wire logic [7:0] KEY_CHAR,
    input wire logic [7:0] KEY_MOD
);
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_B);
    // ===================
    // Assertions
    busy_rise_a: assert property (
        $fell(SER_STROBE_B) && !SER_BUSY |-> ##[3:6] SER_BUSY)
        else $error("busy late after strobe fall");
    busy_hold_a: assert property (
        SER_BUSY && !SER_STROBE_B |=> SER_BUSY)
        else $error("busy dropped while strobe low");
    busy_drop_a: assert property (
        $rose(SER_STROBE_B) && SER_BUSY |-> ##[3:6] !SER_BUSY)
        else $error("busy stuck after strobe rise");
    oe_drop_a: assert property (
        $fell(SER_BUSY) |-> !SER_DATA_OE)
        else $error("data still driven after busy");
    oe_cause_a: assert property (
        $rose(SER_DATA_OE) |-> !$past(SER_STROBE_B, 3))
        else $error("data driven without strobe");
    oe_lead_a: assert property (
        $rose(SER_DATA_OE) |=> $rose(SER_BUSY))
        else $error("busy not one clock after data");
    send_once_a: assert property (
        KEY_SEND |=> !KEY_SEND)
        else $error("keystroke pulse too long");
    send_idle_a: assert property (
        KEY_SEND |-> SER_STROBE_B && !SER_BUSY && !SER_DATA_OE)
        else $error("keystroke outside packet end");
    auto_shift_a: assert property (
        KEY_SEND && KEY_CHAR inside {[8'h41:8'h5A]} |-> KEY_MOD[1])
        else $error("capital sent without shift");
    cover property (KEY_SEND);
    cover property ($rose(SER_DATA_OE));
    cover property (KEY_SEND && KEY_MOD[1]);
endmodule : keyport_monitor
`default_nettype wire

// [sim/serial_host.sv]
// Host controller model for the serial keystroke link
`timescale 1ns/10ps
`default_nettype none
module serial_host (
    input  wire logic clk,
    input  wire logic busy,
    input  wire logic dev_d,
    input  wire logic dev_oe,
    output logic      strobe_b,
    output logic      line
);
    logic host_d_r;
    logic host_oe_r;
    logic last_r;
    initial begin
        strobe_b = 1'b1;
        host_d_r = 1'b0;
        host_oe_r = 1'b0;
        last_r = 1'b0;
    end
    // Undriven line toggles so a stale value never looks valid
    assign line = dev_oe ? dev_d : (host_oe_r ? host_d_r : ~last_r);
    always @(posedge clk) last_r <= line;
    task automatic xfer(input int first, input int n, input int gap,
                        input logic [18:0] din, output logic [5:0] dout);
        for (int i = first; i < first + n; i++) begin
            repeat (gap) @(posedge clk);
            do @(posedge clk); while (busy);
            host_oe_r <= (i < 19);
            host_d_r <= (i < 19) ? din[i] : 1'b0;
            if (i < 19) repeat (100) @(posedge clk);
            strobe_b <= 1'b0;
            do @(posedge clk); while (!busy);
            if (i >= 19) dout[i-19] = line;
            strobe_b <= 1'b1;
        end
        do @(posedge clk); while (busy);
        host_oe_r <= 1'b0;
    endtask : xfer
endmodule : serial_host
`default_nettype wire

// [sim/keyport_tb.sv]
// Self-checking bench for the serial keystroke port
`timescale 1ns/10ps
`default_nettype none
module keyport_tb;
    logic        CLOCK = 1'b0;
    logic        RST_B = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] dat_o;
    logic        ack, strobe_b, line, d_o, d_oe, busy;
    logic [5:0]  dout;
    logic        key_send;
    logic [7:0]  key_char;
    logic [7:0]  key_mod;
    logic [3:0]  sel = 4'hF;
    logic        clash = 1'b0;
    int          sends = 0;
    logic [15:0] tab [5] = '{16'h4102, 16'h5A02, 16'h6100, 16'h7A00,
                             16'h2102};
    int          err_total = 0;
    int          checks_done = 0;
    always #25 CLOCK = ~CLOCK;
    keyport #(.TICK_CYCLES(20), .GAP_MS(19)) dut (
        .CLOCK(CLOCK), .RST_B(RST_B), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
        .WB_DAT_O(dat_o), .WB_ACK_O(ack), .SER_STROBE_B(strobe_b),
        .SER_DATA_I(line), .SER_DATA_O(d_o), .SER_DATA_OE(d_oe),
        .SER_BUSY(busy), .KEY_SEND(key_send), .KEY_CHAR(key_char),
        .KEY_MOD(key_mod));
    serial_host host (.clk(CLOCK), .busy(busy), .dev_d(d_o),
                      .dev_oe(d_oe), .strobe_b(strobe_b), .line(line));
    // Count keystroke pulses; catch both ends driving the data line
    always @(posedge CLOCK) begin
        if (key_send === 1'b1)
            sends <= sends + 1;
        if (d_oe === 1'b1 && host.host_oe_r)
            clash <= 1'b1;
    end
    // ===================
    // Tasks
    task automatic wb(input logic w, input logic [3:0] a,
                      input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge CLOCK); while (ack !== 1'b1);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge CLOCK);
    endtask : wb
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic rd_chk(input string what, input logic [3:0] a,
                          input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(what, exp, rdat);
    endtask : rd_chk
    task automatic pkt(input logic [7:0] ch, input logic [7:0] md,
                       input logic st, input logic [2:0] lk);
        host.xfer(0, 25, 0, {2'b00, st, md, ch}, dout);
        chk("status bits", {29'h0, lk}, {26'h0, dout});
    endtask : pkt
    task automatic print_verdict;
        $display("Checks %0d, errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict
    // ===================
    // Tests
    initial begin
        repeat (20) @(posedge CLOCK);
        RST_B <= 1'b1;
        @(posedge CLOCK);
        rd_chk("stat idle", 4'h8, 32'h0);
        rd_chk("unmapped", 4'hC, 32'h0);
        wb(1'b1, 4'h4, 32'h5);
        rd_chk("lock", 4'h4, 32'h5);
        pkt(8'h61, 8'h81, 1'b0, 3'h5);
        rd_chk("key", 4'h0, 32'h18161);
        sel <= 4'h0;
        wb(1'b1, 4'h4, 32'h7);
        wb(1'b1, 4'h0, 32'h10000);
        sel <= 4'hF;
        rd_chk("lock masked", 4'h4, 32'h5);
        rd_chk("key masked", 4'h0, 32'h18161);
        foreach (tab[k]) begin
            wb(1'b1, 4'h0, 32'h10000);
            pkt(tab[k][15:8], 8'h00, 1'b0, 3'h5);
            rd_chk("shift", 4'h0, {16'h1, tab[k][7:0], tab[k][15:8]});
        end
        wb(1'b1, 4'h0, 32'h10000);
        wb(1'b1, 4'h4, 32'h2);
        pkt(8'h55, 8'h01, 1'b1, 3'h2);
        rd_chk("no send", 4'h0, 32'h221);
        host.xfer(0, 10, 200, 19'h0, dout);
        rd_chk("pos kept", 4'h8, 32'hA);
        repeat (420) @(posedge CLOCK);
        rd_chk("pos reset", 4'h8, 32'h0);
        pkt(8'h31, 8'h10, 1'b0, 3'h2);
        rd_chk("resync", 4'h0, 32'h11031);
        chk("char pin", 32'h31, {24'h0, key_char});
        chk("mod pin", 32'h10, {24'h0, key_mod});
        chk("sends", 32'h7, sends);
        chk("line clash", 32'h0, {31'h0, clash});
        host.xfer(0, 3, 0, 19'h7, dout);
        RST_B <= 1'b0;
        repeat (2) @(posedge CLOCK);
        RST_B <= 1'b1;
        @(posedge CLOCK);
        rd_chk("stat rst", 4'h8, 32'h0);
        rd_chk("lock rst", 4'h4, 32'h0);
        rd_chk("key rst", 4'h0, 32'h0);
        print_verdict();
    end
    // Hang guard, well past the expected run of about 1.04 ms
    initial begin
        #2500000;
        err_total++;
        print_verdict();
    end
endmodule : keyport_tb
bind keyport keyport_monitor u_mon (
    .CLOCK(CLOCK), .RST_B(RST_B), .SER_STROBE_B(SER_STROBE_B),
    .SER_DATA_OE(SER_DATA_OE), .SER_BUSY(SER_BUSY), .KEY_SEND(KEY_SEND),
    .KEY_CHAR(KEY_CHAR), .KEY_MOD(KEY_MOD));
`default_nettype wire
